// ---- pkg/ssm_pkg.sv ----
package ssm_pkg;
	localparam int CLK_KHZ = 10000;
	localparam int CNT_W = 12;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Times in ns, cycles derived
	localparam int FAST_SETTLE_NS = 2000;
	localparam int SLOW_SETTLE_NS = 150000;
	localparam int WAKE_WINDOW_NS = 1000;
	localparam int CORE_RISE_NS = 50000;
	localparam logic [CNT_W-1:0] FAST_SETTLE_CYC =
		CNT_W'((FAST_SETTLE_NS * CLK_KHZ / 1000 + 999) / 1000);
	localparam logic [CNT_W-1:0] SLOW_SETTLE_CYC =
		CNT_W'((SLOW_SETTLE_NS * CLK_KHZ / 1000 + 999) / 1000);
	localparam logic [CNT_W-1:0] WAKE_WINDOW_CYC =
		CNT_W'(WAKE_WINDOW_NS * CLK_KHZ / 1000 / 1000);
	localparam int CORE_RISE_CYC = (CORE_RISE_NS * CLK_KHZ / 1000 + 999) / 1000;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_CORE_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_IO_CTRL = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_FLAG = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_EVT = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_MASK = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_STATE = 8'h14;

	// Side control field positions
	localparam int CTL_SUP_EN = 0;
	localparam int CTL_KEEP = 1;
	localparam int CTL_SUP_FP = 2;
	localparam int CTL_MON_EN = 3;
	localparam int CTL_MON_FP = 4;
	localparam int CTL_AUTO = 5;
	localparam int CTL_W = 6;
	localparam logic [CTL_W-1:0] CTL_RESET = 6'h00;

	// Event bits
	localparam int EVT_CORE_DONE = 0;
	localparam int EVT_IO_DONE = 1;
	localparam int EVT_WAKE_MISS = 2;
	localparam int EVT_LEVEL_RST = 3;
	localparam int EVT_W = 4;
	localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;

	typedef enum logic [1:0] {MON_OFF, MON_NORMAL, MON_FULL} ssm_mon_t;
	typedef enum logic [2:0] {M_RUN, M_LIGHT, M_DEEP, M_WAKE, M_STUCK} ssm_mode_t;
endpackage : ssm_pkg

// ---- src/ssm_timer.sv ----
`timescale 1ns/1ns
module ssm_timer import ssm_pkg::*; #(
	parameter int W = CNT_W
) (
	// Clock and control
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// Load and status
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic busy,
	output logic done
);
	logic [W-1:0] cnt_q, cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (load) begin
			cnt_d = load_val;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - W'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (ce) begin
			cnt_q <= cnt_d;
		end
	end

	assign busy = (cnt_q != '0);
	// Reload on the last count wins; done only for a true expiry
	assign done = ce && !load && (cnt_q == W'(1));
endmodule : ssm_timer

// ---- src/ssm_decode.sv ----
`timescale 1ns/1ns
module ssm_decode import ssm_pkg::*; (
	// Side control bits
	input wire logic [CTL_W-1:0] ctl,
	input wire logic deep,
	// Decoded states
	output ssm_mon_t sup_state,
	output ssm_mon_t mon_state
);
	ssm_mon_t sup_act, mon_act;

	always_comb begin
		sup_act = ctl[CTL_SUP_FP] ? MON_FULL : MON_NORMAL;
		mon_act = ctl[CTL_MON_FP] ? MON_FULL : MON_NORMAL;
		sup_state = MON_OFF;
		mon_state = MON_OFF;
		if (ctl[CTL_SUP_EN]) begin
			if (!deep) begin
				sup_state = sup_act;
			end else if (ctl[CTL_KEEP]) begin
				if (!ctl[CTL_AUTO]) begin
					sup_state = sup_act;
				end else if (ctl[CTL_SUP_FP]) begin
					sup_state = MON_NORMAL;
				end
			end
		end
		if (ctl[CTL_MON_EN]) begin
			if (!deep || !ctl[CTL_AUTO]) begin
				mon_state = mon_act;
			end else if (ctl[CTL_MON_FP]) begin
				mon_state = MON_NORMAL;
			end
		end
	end
endmodule : ssm_decode

// ---- src/ssm_top.sv ----
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ns
module ssm_top import ssm_pkg::*; #(
	parameter int RISE_CYC = CORE_RISE_CYC
) (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// Register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [DATA_W-1:0] rd_data,
	// Power mode requests
	input wire logic light_sleep_req,
	input wire logic deep_sleep_req,
	input wire logic isr_exit_sleep,
	input wire logic wake_irq,
	input wire logic core_level_raise,
	input wire logic soft_power_up_clear,
	// Status outputs
	output ssm_mode_t power_mode,
	output ssm_mon_t core_sup_state,
	output ssm_mon_t core_mon_state,
	output ssm_mon_t io_sup_state,
	output ssm_mon_t io_mon_state,
	output logic wake_slow,
	output logic at_risk,
	output logic core_pending,
	output logic io_pending,
	output logic device_stuck,
	output logic level_reset,
	output logic irq
);
	localparam logic [CNT_W-1:0] RISE_LOAD = CNT_W'(RISE_CYC);

	logic [CTL_W-1:0] core_ctl_q, core_ctl_d, io_ctl_q, io_ctl_d;
	logic [EVT_W-1:0] evt_q, evt_d, mask_q, mask_d, evt_set;
	logic [DATA_W-1:0] rd_q, rd_d;
	logic irq_q, irq_d;
	ssm_mode_t mode_q, mode_d;
	logic [CNT_W-1:0] win_q, win_d, wake_q, wake_d;
	logic hazard_q, hazard_d;
	logic rst_pulse_q, rst_pulse_d;
	logic stuck_q, stuck_d;
	ssm_mon_t c_sup, c_mon, i_sup, i_mon;
	ssm_mon_t c_sup_q, c_mon_q, i_sup_q, i_mon_q;
	logic slow_q, slow_d, risk_q, risk_d;
	logic cpend_q, ipend_q;
	logic wr_core, wr_io, deep;
	logic core_busy, core_done, io_busy, io_done, rise_busy;
	logic core_load, rise_start, entry;

	function automatic logic [CNT_W-1:0] settle_cyc(input logic full_perf);
		settle_cyc = full_perf ? FAST_SETTLE_CYC : SLOW_SETTLE_CYC;
	endfunction : settle_cyc

	function automatic logic risk_of(input logic [CTL_W-1:0] c, input logic [CTL_W-1:0] h);
		logic core_fast, io_sup_hit, io_mon_hit;
		core_fast = !c[CTL_SUP_EN] || c[CTL_SUP_FP] || !c[CTL_MON_EN] || c[CTL_MON_FP];
		io_sup_hit = h[CTL_SUP_EN] && !h[CTL_SUP_FP] && (!h[CTL_KEEP] || h[CTL_AUTO]);
		io_mon_hit = h[CTL_MON_EN] && !h[CTL_MON_FP] && h[CTL_AUTO];
		risk_of = core_fast && (io_sup_hit || io_mon_hit);
	endfunction : risk_of

	assign wr_core = wr_en && (addr == OFS_CORE_CTRL);
	assign wr_io = wr_en && (addr == OFS_IO_CTRL);
	assign deep = (mode_q == M_DEEP) || (mode_q == M_STUCK);
	assign rise_start = core_level_raise && !rise_busy;
	assign core_load = wr_core || rise_start;

	ssm_timer #(.W(CNT_W)) u_core_settle (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.load(core_load),
		.load_val(settle_cyc(core_ctl_d[CTL_SUP_FP])),
		.busy(core_busy),
		.done(core_done)
	);

	ssm_timer #(.W(CNT_W)) u_io_settle (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.load(wr_io),
		.load_val(settle_cyc(io_ctl_d[CTL_SUP_FP])),
		.busy(io_busy),
		.done(io_done)
	);

	// Models the core rail ramp after a level raise
	ssm_timer #(.W(CNT_W)) u_rise (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.load(rise_start),
		.load_val(RISE_LOAD),
		.busy(rise_busy),
		.done()
	);

	ssm_decode u_core_dec (
		.ctl(core_ctl_q),
		.deep(deep),
		.sup_state(c_sup),
		.mon_state(c_mon)
	);

	ssm_decode u_io_dec (
		.ctl(io_ctl_q),
		.deep(deep),
		.sup_state(i_sup),
		.mon_state(i_mon)
	);

	// Register file
	always_comb begin
		core_ctl_d = core_ctl_q;
		io_ctl_d = io_ctl_q;
		mask_d = mask_q;
		if (wr_core) begin
			core_ctl_d = wr_data[CTL_W-1:0];
		end
		if (wr_io) begin
			io_ctl_d = wr_data[CTL_W-1:0];
		end
		if (wr_en && (addr == OFS_MASK)) begin
			mask_d = wr_data[EVT_W-1:0];
		end
		evt_set = '0;
		evt_set[EVT_CORE_DONE] = core_done;
		evt_set[EVT_IO_DONE] = io_done;
		evt_set[EVT_WAKE_MISS] = (mode_d == M_STUCK) && (mode_q != M_STUCK);
		evt_set[EVT_LEVEL_RST] = rst_pulse_d;
		evt_d = evt_q;
		if (wr_en && (addr == OFS_EVT)) begin
			evt_d = evt_q & ~wr_data[EVT_W-1:0];
		end
		// Set beats a same-cycle clear
		evt_d = evt_d | evt_set;
		irq_d = |(evt_d & mask_d);
		rd_d = '0;
		if (rd_en) begin
			unique case (addr)
				OFS_CORE_CTRL: rd_d[CTL_W-1:0] = core_ctl_q;
				OFS_IO_CTRL: rd_d[CTL_W-1:0] = io_ctl_q;
				OFS_FLAG: rd_d[1:0] = {io_busy, core_busy};
				OFS_EVT: rd_d[EVT_W-1:0] = evt_q;
				OFS_MASK: rd_d[EVT_W-1:0] = mask_q;
				OFS_STATE: rd_d[10:0] = {risk_q, slow_q, i_mon_q, i_sup_q, c_mon_q,
					c_sup_q, 1'b0};
				default: rd_d = '0;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			core_ctl_q <= CTL_RESET;
			io_ctl_q <= CTL_RESET;
			evt_q <= EVT_RESET;
			mask_q <= EVT_RESET;
			rd_q <= '0;
			irq_q <= 1'b0;
		end else if (ce) begin
			core_ctl_q <= core_ctl_d;
			io_ctl_q <= io_ctl_d;
			evt_q <= evt_d;
			mask_q <= mask_d;
			rd_q <= rd_d;
			irq_q <= irq_d;
		end
	end

	// Power mode sequencing
	always_comb begin
		mode_d = mode_q;
		win_d = (win_q != '0) ? win_q - CNT_W'(1) : win_q;
		wake_d = (wake_q != '0) ? wake_q - CNT_W'(1) : wake_q;
		hazard_d = hazard_q;
		entry = (deep_sleep_req || isr_exit_sleep)
			&& ((mode_q == M_RUN) || (mode_q == M_LIGHT));
		unique case (mode_q)
			M_RUN: begin
				if (light_sleep_req && !entry) begin
					mode_d = M_LIGHT;
				end
			end
			M_LIGHT: begin
				if (wake_irq && !entry) begin
					mode_d = M_RUN;
				end
			end
			M_DEEP: begin
				if (wake_irq) begin
					if (hazard_q && (win_q != '0)) begin
						mode_d = M_STUCK;
					end else begin
						mode_d = M_WAKE;
						wake_d = settle_cyc(!slow_q);
					end
				end
			end
			M_WAKE: begin
				if (wake_q <= CNT_W'(1)) begin
					mode_d = M_RUN;
				end
			end
			M_STUCK: begin
				// Only a clear from outside recovers, wake interrupts are lost
				if (soft_power_up_clear) begin
					mode_d = M_RUN;
				end
			end
		endcase
		if (entry) begin
			mode_d = M_DEEP;
			win_d = WAKE_WINDOW_CYC;
			// Entering with settling unfinished is as risky as a bad setup
			hazard_d = risk_q || core_busy || io_busy;
		end
		slow_d = core_ctl_q[CTL_MON_EN] && !core_ctl_q[CTL_MON_FP];
		risk_d = risk_of(core_ctl_q, io_ctl_q);
		// Short window expires before the ramp ends
		rst_pulse_d = core_done && rise_busy && core_ctl_q[CTL_SUP_FP];
		// Registered so the stuck pin never glitches on a mode decode
		stuck_d = (mode_d == M_STUCK);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			mode_q <= M_RUN;
			win_q <= '0;
			wake_q <= '0;
			hazard_q <= 1'b0;
			slow_q <= 1'b0;
			risk_q <= 1'b0;
			rst_pulse_q <= 1'b0;
			stuck_q <= 1'b0;
			c_sup_q <= MON_OFF;
			c_mon_q <= MON_OFF;
			i_sup_q <= MON_OFF;
			i_mon_q <= MON_OFF;
			cpend_q <= 1'b0;
			ipend_q <= 1'b0;
		end else if (ce) begin
			mode_q <= mode_d;
			win_q <= win_d;
			wake_q <= wake_d;
			hazard_q <= hazard_d;
			slow_q <= slow_d;
			risk_q <= risk_d;
			rst_pulse_q <= rst_pulse_d;
			stuck_q <= stuck_d;
			c_sup_q <= c_sup;
			c_mon_q <= c_mon;
			i_sup_q <= i_sup;
			i_mon_q <= i_mon;
			cpend_q <= core_busy;
			ipend_q <= io_busy;
		end
	end

	assign rd_data = rd_q;
	assign power_mode = mode_q;
	assign core_sup_state = c_sup_q;
	assign core_mon_state = c_mon_q;
	assign io_sup_state = i_sup_q;
	assign io_mon_state = i_mon_q;
	assign wake_slow = slow_q;
	assign at_risk = risk_q;
	assign core_pending = cpend_q;
	assign io_pending = ipend_q;
	assign device_stuck = stuck_q;
	assign level_reset = rst_pulse_q;
	assign irq = irq_q;
endmodule : ssm_top

// ---- bench/ssm_top_properties.sv ----
`timescale 1ns/1ns
module ssm_top_properties import ssm_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// Requests
	input wire logic deep_sleep_req,
	input wire logic isr_exit_sleep,
	input wire logic wake_irq,
	input wire logic soft_power_up_clear,
	// Status
	input ssm_mode_t power_mode,
	input ssm_mon_t core_mon_state,
	input wire logic wake_slow,
	input wire logic core_pending,
	input wire logic level_reset
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Fast timing is 20 cycles, so a loose band catches slow or stuck exits
	sequence s_fast_wake;
		(power_mode == M_WAKE)[*8] ##[4:20] (power_mode == M_RUN);
	endsequence
	sequence s_entry;
		ce && (power_mode == M_RUN || power_mode == M_LIGHT) && (deep_sleep_req || isr_exit_sleep);
	endsequence
	a_fast_wake: assert property ($rose(power_mode == M_WAKE) && !wake_slow |-> s_fast_wake)
		else $error("fast wake did not return to run in time");
	// Mode must be steady too: the first run cycle after a soft clear still shows the deep decode
	a_slow_flag: assert property (power_mode == M_RUN && $stable(power_mode)
		&& $stable(core_mon_state) |-> wake_slow == (core_mon_state == MON_NORMAL))
		else $error("wake timing flag wrong");
	a_pend_hold: assert property ($rose(core_pending) |-> core_pending[*8])
		else $error("settle pending too short");
	a_level_pulse: assert property ($rose(level_reset) |=> !level_reset)
		else $error("level reset not one cycle");
	a_deep_entry: assert property (s_entry |=> power_mode == M_DEEP)
		else $error("deep entry not taken");
	a_stuck_hold: assert property (ce && power_mode == M_STUCK && !soft_power_up_clear
		|=> power_mode == M_STUCK) else $error("stuck state left early");
	a_stuck_exit: assert property (ce && power_mode == M_STUCK && soft_power_up_clear
		|=> power_mode != M_STUCK) else $error("soft clear did not recover");
	a_stuck_cause: assert property (ce && power_mode == M_DEEP && !wake_irq
		|=> power_mode != M_STUCK) else $error("stuck without interrupt");
endmodule : ssm_top_properties

// ---- bench/ssm_top_bench.sv ----
`timescale 1ns/1ns
module ssm_top_bench import ssm_pkg::*; ;
	logic clock = 0, rst = 1, ce = 1, wr_en = 0, rd_en = 0;
	logic [ADDR_W-1:0] addr = 8'h00;
	logic [DATA_W-1:0] wr_data = 32'h0, rd_data, d;
	logic light_sleep_req = 0, deep_sleep_req = 0, isr_exit_sleep = 0, wake_irq = 0;
	logic core_level_raise = 0, soft_power_up_clear = 0;
	ssm_mode_t power_mode;
	ssm_mon_t core_sup_state, core_mon_state, io_sup_state, io_mon_state;
	logic wake_slow, at_risk, core_pending, io_pending, device_stuck, level_reset, irq;
	int mismatches = 0, checks = 0, n;
	// Rows: at_risk, core control, io control
	logic [12:0] rows [6] = '{{1'b0, 6'h09, 6'h01}, {1'b1, 6'h00, 6'h01}, {1'b0, 6'h1d, 6'h03},
		{1'b1, 6'h1d, 6'h23}, {1'b1, 6'h0d, 6'h28}, {1'b0, 6'h3f, 6'h05}};
	ssm_top #(.RISE_CYC(30)) DUT (.clock(clock), .rst(rst), .ce(ce), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.light_sleep_req(light_sleep_req), .deep_sleep_req(deep_sleep_req),
		.isr_exit_sleep(isr_exit_sleep), .wake_irq(wake_irq), .core_level_raise(core_level_raise),
		.soft_power_up_clear(soft_power_up_clear), .power_mode(power_mode),
		.core_sup_state(core_sup_state), .core_mon_state(core_mon_state),
		.io_sup_state(io_sup_state), .io_mon_state(io_mon_state), .wake_slow(wake_slow),
		.at_risk(at_risk), .core_pending(core_pending), .io_pending(io_pending),
		.device_stuck(device_stuck), .level_reset(level_reset), .irq(irq));
	initial forever #50 clock = ~clock;
	task final_report;
		if (mismatches == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock); wr_en <= 1; addr <= a; wr_data <= v;
		@(posedge clock); wr_en <= 0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clock); rd_en <= 1; addr <= a;
		@(posedge clock); rd_en <= 0;
		#1 d = rd_data;
	endtask : rd
	task settle;
		repeat (3) @(posedge clock);
		n = 0;
		while ((core_pending | io_pending) !== 1'b0 && n < 2000) begin
			@(posedge clock); #1 n++;
		end
	endtask : settle
	task wait_mode(input ssm_mode_t m);
		n = 0;
		// Step off the edge so the mode is read settled
		#1;
		while (power_mode !== m && n < 3000) begin
			@(posedge clock); #1 n++;
		end
		check(32'(power_mode), 32'(m));
	endtask : wait_mode
	// Monitor calls pass keep as 1: it has no keep bit
	function logic [1:0] dec(input logic en, fp, keep, auto, deep);
		if (!en || (deep && !keep)) return 2'h0;
		if (deep && auto) return fp ? 2'h1 : 2'h0;
		return fp ? 2'h2 : 2'h1;
	endfunction : dec
	function logic [8:0] st(input logic [5:0] c, io, input logic deep);
		return {c[3] & ~c[4], dec(io[3], io[4], 1'b1, io[5], deep), dec(io[0], io[2], io[1], io[5],
			deep), dec(c[3], c[4], 1'b1, c[5], deep), dec(c[0], c[2], c[1], c[5], deep)};
	endfunction : st
	initial begin
		#6000000 mismatches++;
		final_report;
	end
	initial begin
		repeat (2) @(posedge clock);
		rst <= 0;
		rd(OFS_CORE_CTRL); check(d, 32'h0);
		for (int i = 0; i < 6; i++) begin
			wr(OFS_CORE_CTRL, 32'(rows[i][11:6])); wr(OFS_IO_CTRL, 32'(rows[i][5:0]));
			rd(OFS_FLAG); check(d & 32'h3, 32'h3);
			check(32'({core_pending, io_pending}), 32'h3);
			settle; rd(OFS_FLAG); check(d & 32'h3, 32'h0);
			rd(OFS_STATE); check(32'(at_risk), 32'(rows[i][12]));
			check(d & 32'h7fe, {21'h0, rows[i][12], st(rows[i][11:6], rows[i][5:0], 0),
				1'b0});
			if (i[0]) begin
				@(posedge clock); light_sleep_req <= 1; @(posedge clock); light_sleep_req <= 0;
			end
			@(posedge clock); isr_exit_sleep <= i[0]; deep_sleep_req <= ~i[0];
			@(posedge clock); isr_exit_sleep <= 0; deep_sleep_req <= 0;
			repeat (2) @(posedge clock);
			#1 check({23'h0, wake_slow, io_mon_state, io_sup_state, core_mon_state, core_sup_state},
				{23'h0, st(rows[i][11:6], rows[i][5:0], 1)});
			@(posedge clock); wake_irq <= 1; @(posedge clock); wake_irq <= 0;
			if (rows[i][12]) begin
				wait_mode(M_STUCK);
				@(posedge clock); #1 check(32'(device_stuck), 32'h1);
				@(posedge clock); soft_power_up_clear <= 1;
				@(posedge clock); soft_power_up_clear <= 0;
				wait_mode(M_RUN);
			end else begin
				wait_mode(M_WAKE); wait_mode(M_RUN);
				check(32'(n > 1000), 32'(rows[i][9] & ~rows[i][10]));
			end
		end
		// Deep entry while settling is pending, on an otherwise safe setup
		wr(OFS_CORE_CTRL, 32'h09); wr(OFS_IO_CTRL, 32'h09);
		@(posedge clock); deep_sleep_req <= 1; @(posedge clock); deep_sleep_req <= 0;
		@(posedge clock); wake_irq <= 1; @(posedge clock); wake_irq <= 0;
		wait_mode(M_STUCK);
		rd(OFS_EVT); check(d & 32'h4, 32'h4);
		@(posedge clock); rst <= 1; @(posedge clock); rst <= 0;
		wait_mode(M_RUN);
		rd(OFS_IO_CTRL); check(d, 32'h0);
		// Risky setup, but the interrupt comes long after the entry window
		wr(OFS_CORE_CTRL, 32'h00); wr(OFS_IO_CTRL, 32'h01); settle;
		@(posedge clock); deep_sleep_req <= 1; @(posedge clock); deep_sleep_req <= 0;
		repeat (1500) @(posedge clock);
		@(posedge clock); wake_irq <= 1; @(posedge clock); wake_irq <= 0;
		wait_mode(M_WAKE); wait_mode(M_RUN);
		wr(OFS_CORE_CTRL, 32'h05); settle;
		@(posedge clock); core_level_raise <= 1; @(posedge clock); core_level_raise <= 0;
		n = 0;
		while (level_reset !== 1'b1 && n < 100) begin
			@(posedge clock); #1 n++;
		end
		check(32'(n > 15 && n < 60), 32'h1);
		rd(OFS_EVT); check(d & 32'h8, 32'h8);
		check(32'(irq), 32'h0);
		wr(OFS_MASK, 32'h8); repeat (2) @(posedge clock);
		#1 check(32'(irq), 32'h1);
		wr(OFS_EVT, 32'h8); repeat (2) @(posedge clock);
		#1 check(32'(irq), 32'h0);
		// Enable low must hold the short settling count where it stands
		wr(OFS_CORE_CTRL, 32'h05); @(posedge clock); ce <= 0;
		repeat (30) @(posedge clock);
		#1 check(32'(core_pending), 32'h1);
		@(posedge clock); ce <= 1; settle;
		// Normal performance covers the ramp, so no reset
		wr(OFS_CORE_CTRL, 32'h01); settle;
		@(posedge clock); core_level_raise <= 1; @(posedge clock); core_level_raise <= 0;
		n = 0;
		repeat (100) begin
			@(posedge clock); #1 n += level_reset;
		end
		check(32'(n), 32'h0);
		check(32'(core_pending), 32'h1);
		rd(8'h20); check(d, 32'h0);
		settle; wr(OFS_FLAG, 32'h3); rd(OFS_FLAG); check(d & 32'h3, 32'h0);
		final_report;
	end
endmodule : ssm_top_bench
bind ssm_top ssm_top_properties PROPS (.clock(clock), .rst(rst), .ce(ce),
	.deep_sleep_req(deep_sleep_req), .isr_exit_sleep(isr_exit_sleep), .wake_irq(wake_irq),
	.soft_power_up_clear(soft_power_up_clear), .power_mode(power_mode),
	.core_mon_state(core_mon_state), .wake_slow(wake_slow), .core_pending(core_pending),
	.level_reset(level_reset));
